// ==== logic/iosd_top.sv ====
// Overview of operation
// - Command 0x12, data number 0x00 replies the input device word, 1 means on.
// - Reply words go out as hex characters, bit 31 first, bit 0 last.
// - Input word bits 0-6 and 10-12 hold the low input devices.
// - Input word bits 16-23 hold stop, mode, dog, program select, override.
// - Input word bits 24-27 and 29-31 hold pause, handwheel, gain, program inputs.
// - Command 0x12, data number 0x40 replies external input pin levels, bits 0-9.
// - Command 0x12, data number 0x60 replies the communication-driven input word.
// - Command 0x12, data number 0xC0 replies external output pin levels, bits 0-6.
// - Command 0x12, data number 0x80 replies the output device word.
// - Output word low half: ready, torque limit, warning, alarm, brakes, battery.
// - Output word bits 17-24 hold home, range, pause, program outputs, sync, done.
// - Command 0x92, data number 0x60 with a word sets communication input devices.
// - Each set word fully replaces the previous one, no merging.
`timescale 1ns/10ps
module iosd_top
  import iosd_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  // decoded command from the framing layer
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [7:0] cmd_code_i,
  input wire logic [7:0] cmd_datano_i,
  input wire logic [31:0] cmd_data_i,
  output logic cmd_ok_o,
  output logic cmd_err_o,
  // reply character stream
  output logic reply_valid_o,
  input wire logic reply_ready_i,
  output logic [7:0] reply_char_o,
  output logic reply_last_o,
  // device state
  input wire logic [31:0] in_dev_i,
  input wire logic [31:0] out_dev_i,
  input wire logic [EXT_IN_W-1:0] ext_in_pins_i,
  input wire logic [EXT_OUT_W-1:0] ext_out_pins_i,
  output logic [31:0] comm_dev_o,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o
);

  // ***********************************************
  // declarations
  // ***********************************************
  localparam logic [31:0] IN_MASK = IN_LO_MASK | IN_MID_MASK | IN_HI_MASK;
  localparam logic [31:0] OUT_MASK = OUT_LO_MASK | OUT_HI_MASK;

  iosd_hex_if hex ();
  iosd_state_t state_q;
  iosd_state_t state_d;
  logic [EXT_IN_W-1:0] ext_in_meta_q;
  logic [EXT_IN_W-1:0] ext_in_q;
  logic [EXT_OUT_W-1:0] ext_out_meta_q;
  logic [EXT_OUT_W-1:0] ext_out_q;
  logic [31:0] comm_q;
  logic [31:0] reply_q;
  logic [31:0] reply_d;
  logic reply_hit;
  logic cmd_take;
  logic is_read;
  logic is_set;
  logic enabled;
  logic exec_read;
  logic exec_set;
  logic refuse;
  logic ok_q;
  logic err_q;
  logic [31:0] ctrl_q;
  logic [EVT_W-1:0] status_q;
  logic [EVT_W-1:0] mask_q;
  logic [EVT_W-1:0] evt;
  logic [EVT_W-1:0] w1c;
  logic bus_req;
  logic ack_q;
  logic bus_wr;
  logic [31:0] rdata_q;

  // ***********************************************
  // pin synchronisers
  // ***********************************************
  // pins are asynchronous; only the second stage feeds the reply mux
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ext_in_meta_q <= '0;
      ext_in_q <= '0;
    end else begin
      ext_in_meta_q <= ext_in_pins_i;
      ext_in_q <= ext_in_meta_q;
    end
  end

  // output pin readback; levels lag the pins by two clocks, a known limitation
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ext_out_meta_q <= '0;
      ext_out_q <= '0;
    end else begin
      ext_out_meta_q <= ext_out_pins_i;
      ext_out_q <= ext_out_meta_q;
    end
  end

  // ***********************************************
  // command decode
  // ***********************************************
  assign enabled = ctrl_q[CTRL_EN_BIT];
  assign cmd_take = cmd_valid_i && (state_q == IOSD_IDLE);
  assign is_read = (cmd_code_i == CMD_READ) && reply_hit;
  assign is_set = (cmd_code_i == CMD_SET) && (cmd_datano_i == DN_COMM_IN);

  // one decision per command, shared by the sequencer, the word and the flags
  assign exec_read = cmd_take && enabled && is_read;
  assign exec_set = cmd_take && enabled && is_set;
  // a disabled block refuses everything, so software can park the link
  assign refuse = cmd_take && !(exec_read || exec_set);

  // select the status word; unassigned positions forced to zero
  always_comb begin
    reply_d = '0;
    reply_hit = 1'b1;
    case (cmd_datano_i)
      DN_IN_DEV: reply_d = in_dev_i & IN_MASK;
      DN_EXT_IN: reply_d = {{(WORD_W-EXT_IN_W){1'b0}}, ext_in_q};
      DN_COMM_IN: reply_d = comm_q & IN_MASK;
      DN_OUT_DEV: reply_d = out_dev_i & OUT_MASK;
      DN_EXT_OUT: reply_d = {{(WORD_W-EXT_OUT_W){1'b0}}, ext_out_q};
      default: reply_hit = 1'b0;
    endcase
  end

  // ***********************************************
  // reply sequencer
  // ***********************************************
  // idle accepts one command; a read holds the link until the last char leaves
  always_comb begin
    state_d = state_q;
    case (state_q)
      // a refused read never leaves idle, so no reply frame is started
      IOSD_IDLE: begin
        if (exec_read) begin
          state_d = IOSD_LOAD;
        end
      end
      IOSD_LOAD: state_d = IOSD_SEND;
      IOSD_SEND: begin
        if (!hex.busy) begin
          state_d = IOSD_IDLE;
        end
      end
      default: state_d = IOSD_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_q <= IOSD_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // word snapshot taken at acceptance so the reply is self-consistent
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      reply_q <= '0;
    end else if (exec_read) begin
      reply_q <= reply_d;
    end
  end

  // ***********************************************
  // communication device word
  // ***********************************************
  // whole-word replace: a cleared bit turns its device off
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      comm_q <= '0;
    end else if (exec_set) begin
      comm_q <= cmd_data_i & IN_MASK;
    end
  end
  assign comm_dev_o = comm_q;

  // completion pulse to the framing layer, one cycle after the take
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ok_q <= 1'b0;
    end else begin
      ok_q <= exec_read || exec_set;
    end
  end

  // refusal pulse; registered so its timing matches a completion
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      err_q <= 1'b0;
    end else begin
      err_q <= refuse;
    end
  end
  assign cmd_ok_o = ok_q;
  assign cmd_err_o = err_q;
  assign cmd_ready_o = (state_q == IOSD_IDLE);

  // ***********************************************
  // hex encoder
  // ***********************************************
  // the framing layer decodes incoming hex replies are encoded here
  assign hex.word = reply_q;
  assign hex.load = (state_q == IOSD_LOAD);
  assign hex.chr_ready = reply_ready_i;
  assign reply_valid_o = hex.chr_valid;
  assign reply_char_o = hex.chr;
  assign reply_last_o = hex.chr_last;

  iosd_hex_tx u_hex (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .hex(hex)
  );

  // ***********************************************
  // interrupt status
  // ***********************************************
  assign evt[EVT_SET] = exec_set;
  assign evt[EVT_READ] = hex.chr_valid && hex.chr_last && reply_ready_i;
  assign evt[EVT_REFUSE] = refuse;
  assign w1c = (bus_wr && avs_address_i == REG_STATUS) ? avs_writedata_i[EVT_W-1:0] : '0;

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~w1c) | evt;
    end
  end

  assign irq_o = |(status_q & mask_q);

  // ***********************************************
  // avalon-mm slave
  // ***********************************************
  // one wait cycle per access, so read data can come from a flop
  assign bus_req = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = bus_req && !ack_q;
  assign bus_wr = avs_write_i && ack_q;

  // ack alternates while a request stands, so every access sees one wait state
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req && !ack_q;
    end
  end

  // control register; only the enable bit is writable, the rest reads zero
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (bus_wr && avs_address_i == REG_CTRL) begin
      ctrl_q <= avs_writedata_i & CTRL_RESET;
    end
  end

  // interrupt mask, same layout as the status register
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mask_q <= '0;
    end else if (bus_wr && avs_address_i == REG_MASK) begin
      mask_q <= avs_writedata_i[EVT_W-1:0];
    end
  end

  // read data captured in the wait cycle; unmapped addresses read zero
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_q <= '0;
    end else if (avs_read_i && !ack_q) begin
      case (avs_address_i)
        REG_CTRL: rdata_q <= ctrl_q;
        REG_STATUS: rdata_q <= {{(WORD_W-EVT_W){1'b0}}, status_q};
        REG_MASK: rdata_q <= {{(WORD_W-EVT_W){1'b0}}, mask_q};
        REG_COMM: rdata_q <= comm_q;
        REG_LAST: rdata_q <= reply_q;
        default: rdata_q <= '0;
      endcase
    end
  end
  assign avs_readdata_o = rdata_q;

endmodule // iosd_top

// ==== logic/iosd_pkg.sv ====
package iosd_pkg;

  // ***********************************************
  // command link codes
  // ***********************************************
  localparam logic [7:0] CMD_READ = 8'h12; // read a status word
  localparam logic [7:0] CMD_SET = 8'h92; // set communication devices
  localparam logic [7:0] DN_IN_DEV = 8'h00; // input device states
  localparam logic [7:0] DN_EXT_IN = 8'h40; // external input pin levels
  localparam logic [7:0] DN_COMM_IN = 8'h60; // communication-driven input devices
  localparam logic [7:0] DN_OUT_DEV = 8'h80; // output device states
  localparam logic [7:0] DN_EXT_OUT = 8'hC0; // external output pin levels

  // ***********************************************
  // word layouts
  // ***********************************************
  localparam int WORD_W = 32;
  localparam int EXT_IN_W = 10;
  localparam int EXT_OUT_W = 7;
  // servo_on..fault_reset_in, position_latch_in, fwd_start, rev_start
  localparam logic [31:0] IN_LO_MASK = 32'h0000_1C7F;
  // forced_stop, auto_manual_sel, home_dog, program_sel_1..4, override_sel
  localparam logic [31:0] IN_MID_MASK = 32'h00FF_0000;
  // pause_resume, handwheel_mult_1/2, gain_switch, prog_input_1..3
  localparam logic [31:0] IN_HI_MASK = 32'hEF00_0000;
  // ready_out, torque_limiting, warning_out, alarm_out, brake_release,
  // dyn_brake_interlock, battery_warning
  localparam logic [31:0] OUT_LO_MASK = 32'h0000_8D89;
  // home_done, in_position_range, paused_out, prog_output_1..3,
  // sync_output, move_done
  localparam logic [31:0] OUT_HI_MASK = 32'h01FE_0000;

  // ***********************************************
  // hex character encoding
  // ***********************************************
  localparam int NIBBLES = 8;
  localparam logic [7:0] ASCII_DIGIT = 8'h30; // '0'
  localparam logic [7:0] ASCII_ALPHA = 8'h37; // 'A' minus ten
  localparam logic [3:0] NIB_TEN = 4'hA;

  // ***********************************************
  // register map, byte addresses
  // ***********************************************
  localparam int ADDR_W = 5;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_MASK = 5'h08;
  localparam logic [4:0] REG_COMM = 5'h0C;
  localparam logic [4:0] REG_LAST = 5'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int EVT_W = 3;
  localparam int EVT_SET = 0; // set word applied
  localparam int EVT_READ = 1; // status reply sent
  localparam int EVT_REFUSE = 2; // command refused

  typedef enum logic [1:0] {
    IOSD_IDLE = 2'b00,
    IOSD_LOAD = 2'b01,
    IOSD_SEND = 2'b11
  } iosd_state_t;

endpackage

// ==== logic/iosd_hex_if.sv ====
`timescale 1ns/10ps
// carries a reply word to the encoder and its character stream back
interface iosd_hex_if;
  logic [31:0] word;
  logic load;
  logic busy;
  logic [7:0] chr;
  logic chr_valid;
  logic chr_ready;
  logic chr_last;
  modport src (output word, output load, output chr_ready,
               input busy, input chr, input chr_valid, input chr_last);
  modport enc (input word, input load, input chr_ready,
               output busy, output chr, output chr_valid, output chr_last);
endinterface // iosd_hex_if

// ==== logic/iosd_hex_tx.sv ====
`timescale 1ns/10ps
module iosd_hex_tx
  import iosd_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  iosd_hex_if.enc hex
);

  logic [31:0] shift_q;
  logic [7:0] chr_q;
  logic [3:0] left_q;

  // one ascii character per nibble, upper case letters
  function automatic logic [7:0] nib_to_ascii(input logic [3:0] nib);
    logic [7:0] base;
    base = (nib < NIB_TEN) ? ASCII_DIGIT : ASCII_ALPHA;
    return 8'(base + {4'h0, nib});
  endfunction

  // ***********************************************
  // shifter: bit 31 leaves first, bit 0 last
  // ***********************************************
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      shift_q <= '0;
      chr_q <= 8'h00;
      left_q <= 4'h0;
    end else if (hex.load && left_q == 4'h0) begin
      chr_q <= nib_to_ascii(hex.word[31:28]);
      shift_q <= {hex.word[27:0], 4'h0};
      left_q <= 4'(NIBBLES);
    end else if (hex.chr_ready && left_q != 4'h0) begin
      chr_q <= nib_to_ascii(shift_q[31:28]);
      shift_q <= {shift_q[27:0], 4'h0};
      left_q <= 4'(left_q - 4'h1);
    end
  end

  assign hex.chr = chr_q;
  assign hex.chr_valid = (left_q != 4'h0);
  assign hex.chr_last = (left_q == 4'h1);
  assign hex.busy = (left_q != 4'h0);

endmodule // iosd_hex_tx

// ==== verif/iosd_master_model.sv ====
`timescale 1ns/10ps
// master station: issues decoded commands and gathers reply characters
module iosd_master_model
  import iosd_pkg::*;
(
  input logic clock_i,
  input logic srst_i,
  input logic slow_i,
  input logic cmd_ready_i,
  input logic cmd_ok_i,
  input logic cmd_err_i,
  input logic reply_valid_i,
  input logic [7:0] reply_char_i,
  input logic reply_last_i,
  output logic cmd_valid_o = 1'b0,
  output logic [7:0] cmd_code_o = 8'h00,
  output logic [7:0] cmd_datano_o = 8'h00,
  output logic [31:0] cmd_data_o = 32'h0,
  output logic reply_ready_o
);
  logic [31:0] acc_q = 32'h0;
  logic [31:0] words_q[$];
  // a slow sink stalls every other cycle, so held characters get exercised
  always @(posedge clock_i) begin
    if (srst_i) reply_ready_o <= 1'b0;
    else reply_ready_o <= slow_i ? ~reply_ready_o : 1'b1;
  end
  // characters come most significant nibble first, eight to a word
  always @(posedge clock_i) begin
    if (reply_valid_i && reply_ready_o) begin
      acc_q = {acc_q[27:0], (reply_char_i > 8'h39) ? 4'(reply_char_i - 8'h37)
                                                   : 4'(reply_char_i - 8'h30)};
      if (reply_last_i) words_q.push_back(acc_q);
    end
  end
  // callers pass the whole device word every time, never a change list
  // the word is handed over decoded, the framing layer owns the hex text
  task automatic send(input logic [7:0] c, input logic [7:0] d, input logic [31:0] w,
                      output logic ok, output logic err);
    cmd_code_o <= c;
    cmd_datano_o <= d;
    cmd_data_o <= w;
    cmd_valid_o <= 1'b1;
    do @(posedge clock_i); while (cmd_ready_i !== 1'b1);
    cmd_valid_o <= 1'b0;
    @(posedge clock_i);
    ok = cmd_ok_i;
    err = cmd_err_i;
  endtask
endmodule // iosd_master_model

// ==== verif/iosd_top_chk.sv ====
`timescale 1ns/10ps
// watches the command, reply and set ports of the block
module iosd_top_chk
  import iosd_pkg::*;
(
  input logic clock_i,
  input logic srst_i,
  input logic cmd_valid_i,
  input logic cmd_ready_o,
  input logic [7:0] cmd_code_i,
  input logic [7:0] cmd_datano_i,
  input logic [31:0] cmd_data_i,
  input logic cmd_ok_o,
  input logic cmd_err_o,
  input logic reply_valid_o,
  input logic reply_ready_i,
  input logic [7:0] reply_char_o,
  input logic reply_last_o,
  input logic [31:0] comm_dev_o
);
  localparam logic [31:0] IM = 32'hEFFF_1C7F;
  logic take;
  logic [2:0] nchar_q;
  assign take = cmd_valid_i && cmd_ready_o;
  // counts accepted characters; wraps at eight, one word per wrap
  always_ff @(posedge clock_i) begin
    if (srst_i) nchar_q <= 3'h0;
    else if (reply_valid_o && reply_ready_i) nchar_q <= nchar_q + 3'h1;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  a_take_answer:
    assert property (take |=> cmd_ok_o != cmd_err_o) else $error("no single answer");
  a_set_applies:
    assert property (take && cmd_code_i == CMD_SET && cmd_datano_i == DN_COMM_IN
      |=> cmd_err_o || comm_dev_o == ($past(cmd_data_i) & IM)) else $error("set not applied");
  a_comm_holds:
    assert property (!(take && cmd_code_i == CMD_SET) |=> $stable(comm_dev_o))
      else $error("comm word moved without a set");
  a_unused_zero:
    assert property ((comm_dev_o & ~IM) == 32'h0) else $error("unassigned comm bit set");
  a_last_eighth:
    assert property (reply_valid_o |-> reply_last_o == (nchar_q == 3'h7))
      else $error("last flag not on eighth char");
  a_char_hex:
    assert property (reply_valid_o |-> reply_char_o inside {[8'h30:8'h39], [8'h41:8'h46]})
      else $error("reply char not hex");
  a_char_held:
    assert property (reply_valid_o && !reply_ready_i |=> reply_valid_o && $stable(reply_char_o))
      else $error("stalled char not held");
  a_read_reply:
    assert property (take && cmd_code_i == CMD_READ |=> cmd_err_o or (cmd_ok_o ##1 reply_valid_o))
      else $error("read gave no reply");
  a_busy_refuse:
    assert property (reply_valid_o |-> !cmd_ready_o) else $error("ready during reply");
endmodule // iosd_top_chk
bind iosd_top iosd_top_chk chk_i (.clock_i, .srst_i, .cmd_valid_i, .cmd_ready_o, .cmd_code_i,
  .cmd_datano_i, .cmd_data_i, .cmd_ok_o, .cmd_err_o, .reply_valid_o, .reply_ready_i,
  .reply_char_o, .reply_last_o, .comm_dev_o);

// ==== verif/tb_io_status_device_onoff_cmds.sv ====
`timescale 1ns/10ps
module tb_io_status_device_onoff_cmds;
  import iosd_pkg::*;
  localparam int IM = 32'hEFFF_1C7F; // input word bits
  localparam int OM = 32'h01FE_8D89; // output word bits
  logic clock_i = 1'b0, srst_i = 1'b1, slow = 1'b0, ok, err, irq_o;
  logic cmd_valid_i, cmd_ready_o, cmd_ok_o, cmd_err_o, reply_valid_o, reply_ready_i;
  logic reply_last_o, avs_read_i = 1'b0, avs_write_i = 1'b0, avs_waitrequest_o;
  logic [7:0] cmd_code_i, cmd_datano_i, reply_char_o;
  logic [31:0] cmd_data_i, comm_dev_o, avs_readdata_o, rd, w, lfsr = 32'hD85DE169;
  logic [31:0] in_dev_i = 32'h0, out_dev_i = 32'h0, avs_writedata_i = 32'h0;
  logic [EXT_IN_W-1:0] ext_in_pins_i = '0;
  logic [EXT_OUT_W-1:0] ext_out_pins_i = '0;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic [7:0] dn_tab[5] = '{DN_IN_DEV, DN_EXT_IN, DN_COMM_IN, DN_OUT_DEV, DN_EXT_OUT};
  logic [15:0] bad_tab[3] = '{16'h1220, 16'h9200, 16'h5560};
  int errors = 0, cmp_count = 0, cyc = 0, comm_m = 0, last_m = 0;
  int exp_q[$];
  always #5 clock_i = ~clock_i;
  iosd_top uut (.clock_i, .srst_i, .cmd_valid_i, .cmd_ready_o, .cmd_code_i, .cmd_datano_i,
    .cmd_data_i, .cmd_ok_o, .cmd_err_o, .reply_valid_o, .reply_ready_i, .reply_char_o,
    .reply_last_o, .in_dev_i, .out_dev_i, .ext_in_pins_i, .ext_out_pins_i, .comm_dev_o,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
    .avs_waitrequest_o, .irq_o);
  iosd_master_model m (.clock_i, .srst_i, .slow_i(slow), .cmd_ready_i(cmd_ready_o),
    .cmd_ok_i(cmd_ok_o), .cmd_err_i(cmd_err_o), .reply_valid_i(reply_valid_o),
    .reply_char_i(reply_char_o), .reply_last_i(reply_last_o), .cmd_valid_o(cmd_valid_i),
    .cmd_code_o(cmd_code_i), .cmd_datano_o(cmd_datano_i), .cmd_data_o(cmd_data_i),
    .reply_ready_o(reply_ready_i));
  // ***********************************************
  // helpers
  // ***********************************************
  function automatic logic [31:0] nxt();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h0400_0007 : 32'h0);
    return lfsr;
  endfunction
  // reference reply word for each data number
  function automatic int model(input logic [7:0] d);
    case (d)
      8'h00: return in_dev_i & IM;
      8'h40: return int'(ext_in_pins_i);
      8'h60: return comm_m;
      8'h80: return out_dev_i & OM;
      default: return int'(ext_out_pins_i);
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one avalon transfer; request held until waitrequest is seen low
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end
  // ***********************************************
  // sequence
  // ***********************************************
  initial begin
    repeat (6) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    for (int a = 0; a < 24; a += 4) begin
      av(1'b0, 5'(a), 32'h0);
      chk(rd, (a == 0) ? 32'h1 : 32'h0);
    end
    // an all-ones word then a single bit shows full replacement
    for (int i = 0; i < 6; i++) begin
      w = (i == 3) ? 32'hFFFF_FFFF : (i == 4) ? 32'h0000_0001 : nxt();
      m.send(CMD_SET, DN_COMM_IN, w, ok, err);
      comm_m = w & IM;
      chk(32'({ok, err}), 32'h2);
      chk(comm_dev_o, comm_m);
    end
    for (int p = 0; p < 2; p++) begin
      slow <= p[0];
      foreach (dn_tab[j]) begin
        in_dev_i <= nxt();
        out_dev_i <= nxt();
        ext_in_pins_i <= 10'(nxt());
        ext_out_pins_i <= 7'(nxt());
        repeat (3) @(posedge clock_i);
        last_m = model(dn_tab[j]);
        exp_q.push_back(last_m);
        m.send(CMD_READ, dn_tab[j], 32'h0, ok, err);
        chk(32'({ok, err}), 32'h2);
        for (int k = 0; k < 100 && m.words_q.size() == 0; k++) @(posedge clock_i);
        chk(32'(m.words_q.size()), 32'h1);
        chk(m.words_q.pop_front(), exp_q.pop_front());
      end
    end
    av(1'b0, REG_LAST, 32'h0);
    chk(rd, last_m);
    foreach (bad_tab[i]) begin
      m.send(bad_tab[i][15:8], bad_tab[i][7:0], nxt(), ok, err);
      chk(32'({ok, err}), 32'h1);
      chk(comm_dev_o, comm_m);
    end
    av(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h7);
    chk(32'(irq_o), 32'h0);
    av(1'b1, REG_MASK, 32'h2);
    chk(32'(irq_o), 32'h1);
    av(1'b1, REG_STATUS, 32'h2);
    chk(32'(irq_o), 32'h0);
    av(1'b1, REG_MASK, 32'h7);
    chk(32'(irq_o), 32'h1);
    av(1'b1, REG_STATUS, 32'h7);
    chk(32'(irq_o), 32'h0);
    // disabled block refuses and leaves the comm word alone
    av(1'b1, REG_CTRL, 32'h0);
    m.send(CMD_SET, DN_COMM_IN, nxt(), ok, err);
    chk(32'({ok, err}), 32'h1);
    chk(comm_dev_o, comm_m);
    av(1'b1, REG_CTRL, 32'h1);
    av(1'b1, REG_COMM, 32'h0);
    av(1'b1, 5'h14, 32'hFFFF_FFFF);
    av(1'b0, REG_COMM, 32'h0);
    chk(rd, comm_m);
    av(1'b0, 5'h14, 32'h0);
    chk(rd, 32'h0);
    end_of_test();
  end
endmodule // tb_io_status_device_onoff_cmds
